// File: pixel_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // ready only looks at the stored count, so a full fifo never accepts even if a pop is pending
  assign o_in_ready  = (count != CNT_FULL);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and count next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
    end
    if (push && !pop) begin
      next_count = count + CNT_ONE;
    end else if (pop && !push) begin
      next_count = count - CNT_ONE;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // storage, one flop word per entry
  // ----------------------------------------------------------------
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    logic [WIDTH-1:0] next_word;
    always_comb begin
      next_word = mem[e];
      if (push && (wr_ptr == PW'(e))) begin
        next_word = i_in_data;
      end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
        mem[e] <= '0;
      end else begin
        mem[e] <= next_word;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import video_mode_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  d;
    logic [2:0]  k;
    logic [24:0] e;
  } row_s;
  localparam logic [7:0] M = REG_MAIN_MODE_CONTROL;
  localparam logic [7:0] S = REG_SYNC_MODE_CONTROL;
  localparam logic [7:0] P = REG_PLL_CONFIGURATION;

  logic        i_clock;
  logic        i_rst_b;
  logic [1:0]  i_std_select_pins;
  logic        i_format_pin;
  logic        i_reg_write;
  logic        i_reg_read;
  logic [7:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata;
  logic [7:0]  o_reg_rdata;
  logic        o_pll_enable;
  logic        o_pll_ref_25mhz;
  logic [2:0]  o_operating_mode;
  logic        o_mode_valid;
  logic [24:0] o_sample_rate_hz;
  logic [1:0]  o_output_format;
  logic        o_embedded_sync;
  logic [1:0]  o_line_correction;
  logic        i_pix_valid;
  logic [7:0]  i_pix_data;
  logic        i_pix_last;
  logic        o_pix_ready;
  logic        o_out_valid;
  logic [7:0]  o_out_data;
  logic        o_out_last;
  logic        i_out_ready;
  logic        stall;
  int          fails;
  int          comparisons;

  // k picks the output: 0 pll on, 1 ref, 2 mode, 3 valid, 4 rate, 5 format, 6 embedded, 7 correction
  localparam row_s ROWS [24] = '{
    '{P, 8'h00, 3'd0, 25'h1}, '{P, 8'hc0, 3'd0, 25'h0}, '{P, 8'h40, 3'd1, 25'h1}, '{P, 8'h80, 3'd1, 25'h0},
    '{M, 8'h01, 3'd4, RATE_601_HZ}, '{M, 8'h09, 3'd4, RATE_NTSC_SQUARE_HZ}, '{M, 8'h11, 3'd4, RATE_NTSC_4FSC_HZ},
    '{M, 8'h11, 3'd2, 25'h2}, '{M, 8'h19, 3'd3, 25'h0}, '{M, 8'h19, 3'd4, RATE_601_HZ}, '{M, 8'h21, 3'd2, 25'h4},
    '{M, 8'h29, 3'd4, RATE_PAL_SQUARE_HZ}, '{M, 8'h31, 3'd3, 25'h0}, '{M, 8'h39, 3'd3, 25'h0},
    '{M, 8'h29, 3'd3, 25'h1}, '{M, 8'h41, 3'd5, 25'h1}, '{M, 8'h41, 3'd6, 25'h0}, '{M, 8'h01, 3'd6, 25'h1},
    '{M, 8'h40, 3'd2, 25'h5}, '{M, 8'h40, 3'd4, RATE_PAL_SQUARE_HZ}, '{M, 8'h40, 3'd5, 25'h0},
    '{S, 8'h00, 3'd7, 25'h0}, '{S, 8'h80, 3'd7, 25'h2}, '{S, 8'h40, 3'd7, 25'h1}
  };

  video_mode_clock_fifo_ctrl u_video_mode_clock_fifo_ctrl (.*);

  video_sink u_video_sink (
    .i_clock     (i_clock),
    .i_stall     (stall),
    .i_out_valid (o_out_valid),
    .i_out_data  (o_out_data),
    .i_out_last  (o_out_last),
    .o_out_ready (i_out_ready)
  );

  // 100 ns period; with the pll off this stands for the outside clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  function automatic logic [24:0] obs(input logic [2:0] k);
    case (k)
      3'd0: obs = {24'h0, o_pll_enable};
      3'd1: obs = {24'h0, o_pll_ref_25mhz};
      3'd2: obs = {22'h0, o_operating_mode};
      3'd3: obs = {24'h0, o_mode_valid};
      3'd4: obs = o_sample_rate_hz;
      3'd5: obs = {23'h0, o_output_format};
      3'd6: obs = {24'h0, o_embedded_sync};
      default: obs = {23'h0, o_line_correction};
    endcase
  endfunction

  function automatic logic [7:0] pat(input int j);
    pat = 8'(j * 7 + 3);
  endfunction

  task chk(input logic [24:0] g, input logic [24:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task results;
    if (fails == 0 && comparisons != 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one-cycle strobes, launched and dropped at falling edges
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_reg_write = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    i_reg_write = 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(negedge i_clock);
    i_reg_read = 1'b1;
    i_reg_addr = a;
    @(negedge i_clock);
    i_reg_read = 1'b0;
    @(negedge i_clock);
  endtask

  // words held until ready is seen high ahead of the taking edge
  task automatic send(input int n, output int refused);
    int w;
    refused = 0;
    for (int j = 0; j < n; j++) begin
      @(negedge i_clock);
      i_pix_valid = 1'b1;
      i_pix_data = pat(j);
      i_pix_last = (j == n - 1);
      w = 0;
      while (o_pix_ready !== 1'b1 && w < 500) begin
        @(negedge i_clock);
        w++;
      end
      refused += w;
      if (w == 500) begin
        fails++;
        results();
      end
    end
    @(negedge i_clock);
    i_pix_valid = 1'b0;
    i_pix_last = 1'b0;
  endtask

  // one line through the buffer; short lines pad, long lines are cut at len words
  task automatic run(input logic [1:0] lc, input int n, input int len, input logic st);
    int w;
    int refused;
    logic [7:0] fill;
    wr(S, {lc, 6'h00});
    repeat (3) @(negedge i_clock);
    stall = st;
    u_video_sink.got.delete();
    send(n, refused);
    w = 0;
    while (u_video_sink.got.size() < len && w < 20000) begin
      @(negedge i_clock);
      w++;
    end
    if (w == 20000) begin
      fails++;
      results();
    end
    repeat (40) @(negedge i_clock);
    stall = 1'b0;
    fill = (lc == LINE_CORR_FIFO1) ? FILL_BLACK : pat(n - 1);
    chk(25'(u_video_sink.got.size()), 25'(len));
    chk({24'h0, o_out_valid}, 25'h0);
    chk({24'h0, refused != 0}, {24'h0, st && (n > FIFO_DEPTH)});
    for (int j = 0; j < len; j++) begin
      chk(25'(u_video_sink.got[j]), {16'h0, j == len - 1, j < n ? pat(j) : fill});
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    i_std_select_pins = 2'h3;
    i_format_pin = 1'b0;
    i_reg_write = 1'b0;
    i_reg_read = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_pix_valid = 1'b0;
    i_pix_data = 8'h00;
    i_pix_last = 1'b0;
    stall = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (16) @(negedge i_clock);
    i_rst_b = 1'b1;
    // table rows; correction code 11 is never written
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      repeat (2) @(negedge i_clock);
      chk(obs(ROWS[i].k), ROWS[i].e);
      rd(ROWS[i].a);
      chk({17'h0, o_reg_rdata}, {17'h0, ROWS[i].d});
    end
    // straps act live while bit 0 of main mode is clear
    i_std_select_pins = 2'h1;
    i_format_pin = 1'b1;
    repeat (3) @(negedge i_clock);
    chk({22'h0, o_operating_mode}, 25'h1);
    chk({23'h0, o_output_format}, 25'h1);
    // reset in mid-run brings the defaults back
    i_rst_b = 1'b0;
    repeat (16) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (2) @(negedge i_clock);
    rd(M);
    chk({17'h0, o_reg_rdata}, {17'h0, MAIN_MODE_RESET});
    rd(S);
    chk({17'h0, o_reg_rdata}, {17'h0, SYNC_MODE_RESET});
    chk({23'h0, o_line_correction}, {23'h0, LINE_CORR_FIFO2});
    chk({24'h0, o_pll_enable}, 25'h1);
    // unmapped place ignores writes and reads as zero
    wr(8'h10, 8'h5a);
    rd(8'h10);
    chk({17'h0, o_reg_rdata}, 25'h0);
    rd(P);
    chk({17'h0, o_reg_rdata}, {17'h0, PLL_CONFIG_RESET});
    // stream in the 601 mode
    wr(M, 8'h01);
    run(LINE_CORR_THROUGH, 5, 5, 1'b1);
    run(LINE_CORR_FIFO1, 3, int'(LINE_LEN_601), 1'b0);
    run(LINE_CORR_FIFO2, 3, int'(LINE_LEN_601), 1'b1);
    run(LINE_CORR_FIFO1, int'(LINE_LEN_601) + 3, int'(LINE_LEN_601), 1'b0);
    // straps decode the two 601 codes as well
    wr(M, 8'h40);
    i_std_select_pins = 2'h2;
    repeat (3) @(negedge i_clock);
    chk({22'h0, o_operating_mode}, {22'h0, MODE_PAL_601});
    i_std_select_pins = 2'h0;
    repeat (3) @(negedge i_clock);
    chk({22'h0, o_operating_mode}, {22'h0, MODE_NTSC_601});
    results();
  end
endmodule

`default_nettype wire

// File: video_mode_chk.sv
`timescale 1ns/10ps
`default_nettype none

module video_mode_chk
  import video_mode_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic [1:0]  i_std_select_pins,
  input wire logic        i_format_pin,
  input wire logic        i_reg_write,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        o_pll_enable,
  input wire logic        o_pll_ref_25mhz,
  input wire logic [2:0]  o_operating_mode,
  input wire logic        o_mode_valid,
  input wire logic [24:0] o_sample_rate_hz,
  input wire logic [1:0]  o_output_format,
  input wire logic        o_embedded_sync,
  input wire logic [1:0]  o_line_correction
);
  logic [24:0] exp_rate;
  logic        wr_main;
  logic        wr_sync;
  logic        wr_pll;

  // unused codes fall back to the 601 rate
  always_comb begin
    case (o_operating_mode)
      MODE_NTSC_SQUARE: exp_rate = RATE_NTSC_SQUARE_HZ;
      MODE_NTSC_4FSC:   exp_rate = RATE_NTSC_4FSC_HZ;
      MODE_PAL_SQUARE:  exp_rate = RATE_PAL_SQUARE_HZ;
      default:          exp_rate = RATE_601_HZ;
    endcase
  end

  // write strobes per register
  assign wr_main = i_reg_write && (i_reg_addr == REG_MAIN_MODE_CONTROL);
  assign wr_sync = i_reg_write && (i_reg_addr == REG_SYNC_MODE_CONTROL);
  assign wr_pll  = i_reg_write && (i_reg_addr == REG_PLL_CONFIGURATION);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // a write shows at the status outputs two edges on
  AST_PLL_RUN: assert property (wr_pll |-> ##2 o_pll_enable == !$past(i_reg_wdata[PLL_OFF_BIT], 2))
    else $error("pll enable does not follow bit 7");
  AST_PLL_REF: assert property (wr_pll |-> ##2 o_pll_ref_25mhz == $past(i_reg_wdata[PLL_REF_BIT], 2))
    else $error("reference select does not follow bit 6");
  AST_LINE_CORR: assert property (wr_sync |-> ##2 o_line_correction == $past(i_reg_wdata[LINE_CORR_LSB +: 2], 2))
    else $error("line correction does not follow field");
  AST_MODE_REG: assert property (wr_main && i_reg_wdata[0] |-> ##2 o_operating_mode == $past(i_reg_wdata[5:3], 2))
    else $error("mode does not follow register field");
  AST_MODE_PIN: assert property (wr_main && !i_reg_wdata[0] |->
      ##2 o_operating_mode == {$past(i_std_select_pins[1]), 1'b0, $past(i_std_select_pins[0])})
    else $error("mode does not follow select pins");
  AST_FMT_PIN: assert property (wr_main && !i_reg_wdata[0] |-> ##2 o_output_format == {1'b0, $past(i_format_pin)})
    else $error("format does not follow format pin");
  AST_FMT_REG: assert property (wr_main && i_reg_wdata[0] |-> ##2 o_output_format == $past(i_reg_wdata[7:6], 2))
    else $error("format does not follow register field");
  // the first edge after reset still shows reset values, hence the past guard
  AST_EMBED: assert property ($past(i_rst_b) |-> o_embedded_sync == (o_output_format == FORMAT_EMBEDDED_SYNC))
    else $error("embedded sync flag disagrees with format");
  AST_VALID: assert property ($past(i_rst_b) |-> o_mode_valid == !(o_operating_mode inside {3'h3, 3'h6, 3'h7}))
    else $error("mode valid flag wrong");
  AST_RATE: assert property ($past(i_rst_b) |-> o_sample_rate_hz == exp_rate)
    else $error("sample rate does not match mode");
endmodule

bind video_mode_clock_fifo_ctrl video_mode_chk u_chk (.*);

`default_nettype wire

// File: video_mode_clock_fifo_ctrl.sv
//
// Contract
// - line correction 00 makes every line leave with the standard word count, short lines padded with black.
// - line correction 01, the reset value, also fixes the count but pads by repeating the last pixel.
// - line correction 10 passes pixels straight through with their own line length.
// - format is embedded-sync 4:2:2 for pin 0 or code 00 and muxed 8-bit 4:2:2 for pin 1 or code 01.
// - pll configuration bit 7 low runs the pll, high stops it, and bit 6 picks 32 MHz (0) or 25 MHz (1).
// - with the pll running the line-locked double-speed clock is requested as the system clock.
// - mode comes from the two select pins when main mode bit 0 is 0, else from the three-bit field.
// - field codes 000, 001, 010, 100, 101 pick the modes; 011, 110, 111 must not be selected.
`timescale 1ns/10ps
`default_nettype none

module video_mode_clock_fifo_ctrl
  import video_mode_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [1:0]  i_std_select_pins,
  input  wire logic        i_format_pin,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_pll_enable,
  output logic             o_pll_ref_25mhz,
  output logic      [2:0]  o_operating_mode,
  output logic             o_mode_valid,
  output logic      [24:0] o_sample_rate_hz,
  output logic      [1:0]  o_output_format,
  output logic             o_embedded_sync,
  output logic      [1:0]  o_line_correction,
  input  wire logic        i_pix_valid,
  input  wire logic [7:0]  i_pix_data,
  input  wire logic        i_pix_last,
  output logic             o_pix_ready,
  output logic             o_out_valid,
  output logic      [7:0]  o_out_data,
  output logic             o_out_last,
  input  wire logic        i_out_ready
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] main_mode_control;
  logic [7:0] sync_mode_control;
  logic [7:0] pll_configuration;
  logic [7:0] reg_rdata;
  logic [7:0] next_main_mode_control;
  logic [7:0] next_sync_mode_control;
  logic [7:0] next_pll_configuration;
  logic [7:0] next_reg_rdata;

  // writes update the addressed register, reads capture it; unmapped reads return zero
  always_comb begin
    next_main_mode_control = main_mode_control;
    next_sync_mode_control = sync_mode_control;
    next_pll_configuration = pll_configuration;
    next_reg_rdata         = reg_rdata;
    if (i_reg_write) begin
      case (i_reg_addr)
        REG_MAIN_MODE_CONTROL: next_main_mode_control = i_reg_wdata;
        REG_SYNC_MODE_CONTROL: next_sync_mode_control = i_reg_wdata;
        REG_PLL_CONFIGURATION: next_pll_configuration = i_reg_wdata;
        default:               next_reg_rdata = reg_rdata;
      endcase
    end
    if (i_reg_read) begin
      case (i_reg_addr)
        REG_MAIN_MODE_CONTROL: next_reg_rdata = main_mode_control;
        REG_SYNC_MODE_CONTROL: next_reg_rdata = sync_mode_control;
        REG_PLL_CONFIGURATION: next_reg_rdata = pll_configuration;
        default:               next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      main_mode_control <= MAIN_MODE_RESET;
      sync_mode_control <= SYNC_MODE_RESET;
      pll_configuration <= PLL_CONFIG_RESET;
      reg_rdata         <= '0;
    end else begin
      main_mode_control <= next_main_mode_control;
      sync_mode_control <= next_sync_mode_control;
      pll_configuration <= next_pll_configuration;
      reg_rdata         <= next_reg_rdata;
    end
  end

  assign o_reg_rdata = reg_rdata;

  // ----------------------------------------------------------------
  // mode, format and clock selection
  // ----------------------------------------------------------------
  logic [2:0]  mode_sel;
  logic [1:0]  format_sel;
  logic [1:0]  corr_sel;
  logic [10:0] line_len;
  logic [24:0] rate_sel;
  logic        mode_ok;

  // with main mode bit 0 clear, straps are sampled every cycle, so a pin change reaches line_len at once, even mid-line, and status outputs one edge later
  always_comb begin
    if (!main_mode_control[MODE_SOURCE_BIT]) begin
      case (i_std_select_pins)
        PIN_NTSC_601:    mode_sel = MODE_NTSC_601;
        PIN_NTSC_SQUARE: mode_sel = MODE_NTSC_SQUARE;
        PIN_PAL_601:     mode_sel = MODE_PAL_601;
        default:         mode_sel = MODE_PAL_SQUARE;
      endcase
      format_sel = {1'b0, i_format_pin};
    end else begin
      mode_sel   = main_mode_control[MODE_CODE_LSB +: 3];
      format_sel = main_mode_control[FORMAT_LSB +: 2];
    end
    mode_ok = 1'b1;
    case (mode_sel)
      MODE_NTSC_601: begin
        line_len = LINE_LEN_601;
        rate_sel = RATE_601_HZ;
      end
      MODE_NTSC_SQUARE: begin
        line_len = LINE_LEN_NTSC_SQUARE;
        rate_sel = RATE_NTSC_SQUARE_HZ;
      end
      MODE_NTSC_4FSC: begin
        line_len = LINE_LEN_4FSC;
        rate_sel = RATE_NTSC_4FSC_HZ;
      end
      MODE_PAL_601: begin
        line_len = LINE_LEN_601;
        rate_sel = RATE_601_HZ;
      end
      MODE_PAL_SQUARE: begin
        line_len = LINE_LEN_PAL_SQUARE;
        rate_sel = RATE_PAL_SQUARE_HZ;
      end
      default: begin
        // unused codes fall back to 601 timing so the stream never hangs
        mode_ok  = 1'b0;
        line_len = LINE_LEN_601;
        rate_sel = RATE_601_HZ;
      end
    endcase
    corr_sel = sync_mode_control[LINE_CORR_LSB +: 2];
  end

  // registered status outputs
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pll_enable      <= 1'b0;
      o_pll_ref_25mhz   <= 1'b0;
      o_operating_mode  <= MODE_NTSC_601;
      o_mode_valid      <= 1'b0;
      o_sample_rate_hz  <= '0;
      o_output_format   <= FORMAT_MUX_8BIT;
      o_embedded_sync   <= 1'b0;
      o_line_correction <= LINE_CORR_FIFO2;
    end else begin
      o_pll_enable      <= !pll_configuration[PLL_OFF_BIT];
      o_pll_ref_25mhz   <= pll_configuration[PLL_REF_BIT];
      o_operating_mode  <= mode_sel;
      o_mode_valid      <= mode_ok;
      o_sample_rate_hz  <= rate_sel;
      o_output_format   <= format_sel;
      o_embedded_sync   <= (format_sel == FORMAT_EMBEDDED_SYNC);
      o_line_correction <= corr_sel;
    end
  end

  // ----------------------------------------------------------------
  // pixel count correction
  // ----------------------------------------------------------------
  fill_state_e state;
  fill_state_e next_state;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic [1:0]  corr;
  logic [1:0]  next_corr;
  logic [7:0]  held_pix;
  logic [7:0]  next_held_pix;
  logic        push;
  logic [8:0]  push_word;
  logic        fifo_in_ready;
  logic [8:0]  fifo_out_word;

  // correction mode is latched at a line's first pixel so a change never splits a line
  always_comb begin
    logic [1:0] use_corr;
    use_corr      = (cnt == '0) ? corr_sel : corr;
    next_state    = state;
    next_cnt      = cnt;
    next_corr     = corr;
    next_held_pix = held_pix;
    push          = 1'b0;
    push_word     = {1'b0, i_pix_data};
    o_pix_ready   = 1'b0;
    case (state)
      st_pass: begin
        o_pix_ready = fifo_in_ready;
        if (i_pix_valid && fifo_in_ready) begin
          next_corr     = use_corr;
          next_held_pix = i_pix_data;
          push          = 1'b1;
          if (use_corr[1]) begin
            push_word = {i_pix_last, i_pix_data};
            next_cnt  = i_pix_last ? '0 : cnt + LINE_ONE;
          end else if (cnt == line_len - LINE_ONE) begin
            push_word = {1'b1, i_pix_data};
            next_cnt  = '0;
            if (!i_pix_last) begin
              next_state = st_drop;
            end
          end else begin
            next_cnt = cnt + LINE_ONE;
            if (i_pix_last) begin
              next_state = st_pad;
            end
          end
        end
      end
      st_pad: begin
        // input is stalled while the line is filled up to its standard length
        if (fifo_in_ready) begin
          push      = 1'b1;
          push_word = {(cnt == line_len - LINE_ONE),
                       (corr == LINE_CORR_FIFO1) ? FILL_BLACK : held_pix};
          if (cnt == line_len - LINE_ONE) begin
            next_cnt   = '0;
            next_state = st_pass;
          end else begin
            next_cnt = cnt + LINE_ONE;
          end
        end
      end
      st_drop: begin
        // surplus pixels of a long line are discarded up to its last one
        o_pix_ready = 1'b1;
        if (i_pix_valid && i_pix_last) begin
          next_state = st_pass;
        end
      end
      default: next_state = st_pass;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state    <= st_pass;
      cnt      <= '0;
      corr     <= LINE_CORR_FIFO2;
      held_pix <= FILL_BLACK;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      corr     <= next_corr;
      held_pix <= next_held_pix;
    end
  end

  // ----------------------------------------------------------------
  // output buffer, downstream back-pressure reaches o_pix_ready
  // ----------------------------------------------------------------
  pixel_fifo #(
    .WIDTH (PIX_WIDTH + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push),
    .i_in_data   (push_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_out_valid),
    .o_out_data  (fifo_out_word),
    .i_out_ready (i_out_ready)
  );

  assign o_out_data = fifo_out_word[7:0];
  assign o_out_last = fifo_out_word[8];

endmodule
`default_nettype wire

// File: video_mode_pkg.sv
package video_mode_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MAIN_MODE_CONTROL = 8'h00;
  localparam logic [7:0] REG_SYNC_MODE_CONTROL = 8'h03;
  localparam logic [7:0] REG_PLL_CONFIGURATION = 8'h20;

  localparam logic [7:0] MAIN_MODE_RESET = 8'h40;  // pins select mode, format 01
  localparam logic [7:0] SYNC_MODE_RESET = 8'h40;  // line correction 01
  localparam logic [7:0] PLL_CONFIG_RESET = 8'h00; // pll on, 32 MHz reference

  // field positions
  localparam int MODE_SOURCE_BIT = 0;
  localparam int MODE_CODE_LSB   = 3;
  localparam int FORMAT_LSB      = 6;
  localparam int LINE_CORR_LSB   = 6;
  localparam int PLL_OFF_BIT     = 7;
  localparam int PLL_REF_BIT     = 6;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LINE_CORR_FIFO1   = 2'h0;
  localparam logic [1:0] LINE_CORR_FIFO2   = 2'h1;
  localparam logic [1:0] LINE_CORR_THROUGH = 2'h2;

  localparam logic [1:0] FORMAT_EMBEDDED_SYNC = 2'h0;
  localparam logic [1:0] FORMAT_MUX_8BIT      = 2'h1;

  localparam logic [1:0] PIN_NTSC_601    = 2'h0;
  localparam logic [1:0] PIN_NTSC_SQUARE = 2'h1;
  localparam logic [1:0] PIN_PAL_601     = 2'h2;
  localparam logic [1:0] PIN_PAL_SQUARE  = 2'h3;

  localparam logic [2:0] MODE_NTSC_601    = 3'h0;
  localparam logic [2:0] MODE_NTSC_SQUARE = 3'h1;
  localparam logic [2:0] MODE_NTSC_4FSC   = 3'h2;
  localparam logic [2:0] MODE_PAL_601     = 3'h4;
  localparam logic [2:0] MODE_PAL_SQUARE  = 3'h5;

  // double-speed sampling clock per mode, in Hz
  localparam logic [24:0] RATE_601_HZ         = 25'd27000000;
  localparam logic [24:0] RATE_NTSC_SQUARE_HZ = 25'd24545454;
  localparam logic [24:0] RATE_NTSC_4FSC_HZ   = 25'd28636360;
  localparam logic [24:0] RATE_PAL_SQUARE_HZ  = 25'd29500000;

  // standard output words per line (4:2:2, two bytes per pixel)
  localparam int          LINE_WIDTH          = 11;
  localparam logic [10:0] LINE_LEN_601         = 11'd1440;
  localparam logic [10:0] LINE_LEN_NTSC_SQUARE = 11'd1280;
  localparam logic [10:0] LINE_LEN_4FSC        = 11'd1536;
  localparam logic [10:0] LINE_LEN_PAL_SQUARE  = 11'd1536;
  localparam logic [10:0] LINE_ONE             = 11'd1;

  localparam logic [7:0] FILL_BLACK = 8'h10;
  localparam int         PIX_WIDTH  = 8;
  localparam int         FIFO_DEPTH = 4;

  typedef enum logic [1:0] {st_pass, st_pad, st_drop} fill_state_e;

endpackage

// File: video_sink.sv
`timescale 1ns/10ps
`default_nettype none

module video_sink (
  input  wire logic       i_clock,
  input  wire logic       i_stall,
  input  wire logic       i_out_valid,
  input  wire logic [7:0] i_out_data,
  input  wire logic       i_out_last,
  output logic            o_out_ready
);
  logic [2:0] phase;
  logic [8:0] got [$];

  initial begin
    phase = 3'h0;
    o_out_ready = 1'b1;
  end

  // ready moves off the sampling edge; a stall takes six cycles in eight
  always @(negedge i_clock) begin
    phase <= phase + 3'h1;
    o_out_ready <= !(i_stall && phase < 3'h6);
  end

  // every word taken is kept with its end-of-line flag
  always @(posedge i_clock) begin
    if (i_out_valid && o_out_ready) begin
      got.push_back({i_out_last, i_out_data});
    end
  end
endmodule

`default_nettype wire
